// file: logic/dctom_defines.svh
// timing counts and fault code values for the torque-off monitor
`ifndef DCTOM_DEFINES_SVH
`define DCTOM_DEFINES_SVH
`define DCTOM_CLK_MHZ 100
`define DCTOM_TRIG_MS 10
`define DCTOM_IND_E40_MS 100
`define DCTOM_IND_FLT_MS 280
`define DCTOM_FILT_US 1000
`define DCTOM_FILT_CYC ((`DCTOM_FILT_US * `DCTOM_CLK_MHZ))
`define DCTOM_IND_E40_CYC (((`DCTOM_IND_E40_MS * 1000 - `DCTOM_FILT_US) * `DCTOM_CLK_MHZ) - 8)
`define DCTOM_IND_FLT_CYC (((`DCTOM_IND_FLT_MS * 1000 - `DCTOM_FILT_US) * `DCTOM_CLK_MHZ) - 8)
`define DCTOM_AB_DLY_MS 200
`define DCTOM_AB_DLY_CYC ((`DCTOM_AB_DLY_MS * 1000 * `DCTOM_CLK_MHZ) + 1)
`define DCTOM_CODE_NONE 8'h00
`define DCTOM_CODE_E40 8'h28
`define DCTOM_CODE_E41 8'h29
`define DCTOM_CODE_E42 8'h2A
`define DCTOM_CODE_E43 8'h2B
`endif

// file: logic/dctom_pkg.sv
// types shared by the torque-off monitor
package dctom_pkg;
    typedef enum logic [2:0] {
        DCTOM_ST_RUN = 3'b000,
        DCTOM_ST_E40 = 3'b001,
        DCTOM_ST_E41 = 3'b010,
        DCTOM_ST_E42 = 3'b011,
        DCTOM_ST_E43 = 3'b100
    } dctom_state_e;
endpackage

// file: logic/dctom_filter.sv
// synchroniser plus stability filter for one safe channel
`timescale 1ns/1ps
`default_nettype none
module dctom_filter #(
    parameter int FILT_CYC = 100000
) (
    // clocking
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // channel
    input wire logic raw_closed,
    output logic filt_closed
);
    logic s1_r, s2_r, s1_nxt, s2_nxt;
    logic filt_r, filt_nxt;
    logic [31:0] cnt_r, cnt_nxt;

    // next values: level must hold steady for the whole window to count
    always_comb
    begin
        s1_nxt = raw_closed;
        s2_nxt = s1_r;
        filt_nxt = filt_r;
        cnt_nxt = 32'h0;
        if (s2_r != filt_r)
        begin
            if (cnt_r >= 32'(FILT_CYC - 1))
                filt_nxt = s2_r;
            else
                cnt_nxt = cnt_r + 32'h1;
        end
    end

    // registers; reset to open so power-up is safe
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            filt_r <= 1'b0;
            cnt_r <= 32'h0;
        end
        else if (clk_en)
        begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            filt_r <= filt_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign filt_closed = filt_r;
endmodule
`default_nettype wire

// file: logic/dctom_monitor.sv
// dual channel torque-off monitor: classification, latching, output cutoff
`timescale 1ns/1ps
`default_nettype none
`include "dctom_defines.svh"
module dctom_monitor
    import dctom_pkg::*;
#(
    parameter int FILT_CYC = `DCTOM_FILT_CYC,
    parameter int IND_E40_CYC = `DCTOM_IND_E40_CYC,
    parameter int IND_FLT_CYC = `DCTOM_IND_FLT_CYC,
    parameter int AB_DLY_CYC = `DCTOM_AB_DLY_CYC
) (
    // clocking
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // safe channels, high means contact closed
    input wire logic safe_channel_a,
    input wire logic safe_channel_b,
    // operator controls
    input wire logic start_cmd,
    input wire logic stop_cmd,
    input wire logic fault_reset,
    input wire logic fault_autoreset_setting,
    // drive side
    output logic torque_enable,
    output logic safe_torque_cutoff,
    output logic running,
    // indication
    output logic [7:0] fault_code,
    output logic fault_active
);
    ////////////////////////////////////////////////////////////////
    // channel conditioning
    logic a_closed, b_closed;

    dctom_filter #(.FILT_CYC(FILT_CYC)) u_filt_a (
        .mclk(mclk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .raw_closed(safe_channel_a),
        .filt_closed(a_closed)
    );
    dctom_filter #(.FILT_CYC(FILT_CYC)) u_filt_b (
        .mclk(mclk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .raw_closed(safe_channel_b),
        .filt_closed(b_closed)
    );

    ////////////////////////////////////////////////////////////////
    // discrepancy timer: channels disagreeing longer than the switch
    // transition time is treated as a single-channel fault, so a normal
    // two-contact opening with skew settles as E40, not E41/E42
    logic [31:0] dis_cnt_r, dis_cnt_nxt;
    logic dis_exp;
    logic [31:0] ind_cnt_r, ind_cnt_nxt;

    always_comb
    begin
        dis_cnt_nxt = 32'h0;
        if (a_closed != b_closed)
        begin
            if (dis_cnt_r < 32'(AB_DLY_CYC))
                dis_cnt_nxt = dis_cnt_r + 32'h1;
            else
                dis_cnt_nxt = dis_cnt_r;
        end
    end
    assign dis_exp = (dis_cnt_r >= 32'(AB_DLY_CYC));

    ////////////////////////////////////////////////////////////////
    // fault state machine
    dctom_state_e st_r, st_nxt;
    logic pend_r, pend_nxt;       // a fault is cutting torque but not yet displayed
    logic [2:0] pend_kind_r, pend_kind_nxt;
    logic run_r, run_nxt;
    logic tq_r, tq_nxt;
    logic cut_r, cut_nxt;
    logic [7:0] code_r, code_nxt;
    logic fa_r, fa_nxt;
    logic any_open;
    logic [7:0] disp;

    assign any_open = !a_closed || !b_closed;

    always_comb
    begin
        st_nxt = st_r;
        run_nxt = run_r;
        pend_nxt = pend_r;
        pend_kind_nxt = pend_kind_r;
        ind_cnt_nxt = ind_cnt_r;
        unique case (st_r)
            DCTOM_ST_RUN:
            begin
                if (any_open && !pend_r)
                begin
                    pend_nxt = 1'b1;
                    ind_cnt_nxt = 32'h0;
                end
                else if (pend_r)
                begin
                    ind_cnt_nxt = ind_cnt_r + 32'h1;
                    if (!a_closed && !b_closed)
                    begin
                        if (ind_cnt_r >= 32'(IND_E40_CYC - 1))
                        begin
                            st_nxt = DCTOM_ST_E40;
                            pend_nxt = 1'b0;
                        end
                    end
                    else if (dis_exp)
                    begin
                        st_nxt = a_closed ? DCTOM_ST_E42 : DCTOM_ST_E41;
                        pend_nxt = 1'b0;
                    end
                    else if (!any_open)
                    begin
                        // glitch that healed before indication: still stopped
                        pend_nxt = 1'b0;
                    end
                    else if (ind_cnt_r >= 32'(IND_FLT_CYC - 1))
                    begin
                        st_nxt = a_closed ? DCTOM_ST_E42 : DCTOM_ST_E41;
                        pend_nxt = 1'b0;
                    end
                end
            end
            DCTOM_ST_E40:
            begin
                if (a_closed && b_closed && (fault_reset || fault_autoreset_setting))
                    st_nxt = DCTOM_ST_RUN;
                else if (dis_exp)
                    // one channel stuck while the other recovered
                    st_nxt = DCTOM_ST_E43;
            end
            DCTOM_ST_E41, DCTOM_ST_E42:
            begin
                // latched until power cycle; a later disagreement the
                // other way means both channels have misbehaved
                // both abnormal
                if (dis_exp && ((st_r == DCTOM_ST_E41) ? !b_closed && a_closed : !a_closed && b_closed))
                    st_nxt = DCTOM_ST_E43;
            end
            DCTOM_ST_E43:
            begin
                st_nxt = DCTOM_ST_E43;
            end
            default:
                st_nxt = DCTOM_ST_E43;
        endcase
        pend_kind_nxt = {1'b0, a_closed, b_closed};
        // start ignored and running dropped under any fault
        if (any_open || pend_r || st_r != DCTOM_ST_RUN)
            run_nxt = 1'b0;
        else if (stop_cmd)
            run_nxt = 1'b0;
        else if (start_cmd)
            run_nxt = 1'b1;
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    always_comb
    begin
        unique case (st_r)
            DCTOM_ST_E40: disp = `DCTOM_CODE_E40;
            DCTOM_ST_E41: disp = `DCTOM_CODE_E41;
            DCTOM_ST_E42: disp = `DCTOM_CODE_E42;
            DCTOM_ST_E43: disp = `DCTOM_CODE_E43;
            default: disp = `DCTOM_CODE_NONE;
        endcase
    end

    always_comb
    begin
        // cut within one cycle of the filtered change
        cut_nxt = any_open || pend_r || (st_r != DCTOM_ST_RUN);
        tq_nxt = !cut_nxt && run_nxt;
        code_nxt = disp;
        fa_nxt = (st_r != DCTOM_ST_RUN);
    end

    // state registers
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            st_r <= DCTOM_ST_RUN;
            run_r <= 1'b0;
            pend_r <= 1'b1;      // open at power-up until filters settle
            pend_kind_r <= 3'h0;
            ind_cnt_r <= 32'h0;
            dis_cnt_r <= 32'h0;
            tq_r <= 1'b0;
            cut_r <= 1'b1;
            code_r <= `DCTOM_CODE_NONE;
            fa_r <= 1'b0;
        end
        else if (clk_en)
        begin
            st_r <= st_nxt;
            run_r <= run_nxt;
            pend_r <= pend_nxt;
            pend_kind_r <= pend_kind_nxt;
            ind_cnt_r <= ind_cnt_nxt;
            dis_cnt_r <= dis_cnt_nxt;
            tq_r <= tq_nxt;
            cut_r <= cut_nxt;
            code_r <= code_nxt;
            fa_r <= fa_nxt;
        end
    end

    assign torque_enable = tq_r;
    assign safe_torque_cutoff = cut_r;
    assign running = run_r;
    assign fault_code = code_r;
    assign fault_active = fa_r;
endmodule
`default_nettype wire

// file: test/dctom_monitor_chk.sv
// port checker for the torque-off monitor
`timescale 1ns/1ps
`default_nettype none
module dctom_monitor_chk (
    // clocking
    input wire logic mclk,
    input wire logic rst_n,
    // inputs
    input wire logic safe_channel_a,
    input wire logic safe_channel_b,
    input wire logic start_cmd,
    input wire logic fault_autoreset_setting,
    // outputs
    input wire logic torque_enable,
    input wire logic safe_torque_cutoff,
    input wire logic running,
    input wire logic [7:0] fault_code
);
    // limits suit the shortened bench counts
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_run; running |-> fault_code == 8'h00; endproperty
    a_run: assert property (p_run) else $error("code while running");
    property p_e40; (fault_code == 8'h00 && !safe_channel_a && !safe_channel_b)[*8]
        |-> ##[0:60] fault_code == 8'h28; endproperty
    a_e40: assert property (p_e40) else $error("no E40 code");
    property p_e41; (fault_code == 8'h00 && !safe_channel_a && safe_channel_b)[*8]
        |-> ##[0:120] fault_code == 8'h29; endproperty
    a_e41: assert property (p_e41) else $error("no E41 code");
    property p_cut; (!safe_channel_a || !safe_channel_b)[*8] |-> ##[0:2] safe_torque_cutoff; endproperty
    a_cut: assert property (p_cut) else $error("cutoff late");
    property p_off; safe_torque_cutoff |-> !torque_enable && !running; endproperty
    a_off: assert property (p_off) else $error("power while cut");
    property p_go; $rose(running) |-> $past(start_cmd) || $past(start_cmd, 2); endproperty
    a_go: assert property (p_go) else $error("run without start");
    property p_hold; (fault_code == 8'h29 || fault_code == 8'h2A)
        |=> fault_code == $past(fault_code) || fault_code == 8'h2B; endproperty
    a_hold: assert property (p_hold) else $error("single fault lost");
    property p_auto; (fault_code == 8'h28 && safe_channel_a && safe_channel_b && fault_autoreset_setting)[*8]
        |-> ##[0:2] fault_code == 8'h00; endproperty
    a_auto: assert property (p_auto) else $error("E40 not cleared");
endmodule
////////////////////////////////////////
bind dctom_monitor dctom_monitor_chk chk_u (.mclk, .rst_n, .safe_channel_a, .safe_channel_b, .start_cmd,
    .fault_autoreset_setting, .torque_enable, .safe_torque_cutoff, .running, .fault_code);
`default_nettype wire

// file: test/dctom_contacts.sv
// contact model driving both safe channels
`timescale 1ns/1ps
`default_nettype none
module dctom_contacts (
    // clock
    input wire logic mclk,
    // wanted state, high closes
    input wire logic want_a,
    input wire logic want_b,
    // channel lines
    output logic ch_a,
    output logic ch_b
);
    logic [2:0] dly_a = 3'h0;
    logic [2:0] dly_b = 3'h0;
    always @(negedge mclk)
    begin
        dly_a <= {dly_a[1:0], want_a};
        dly_b <= {dly_b[1:0], want_b};
    end
    assign ch_a = dly_a[2];
    assign ch_b = dly_b[2];
endmodule
`default_nettype wire

// file: test/tb_dual_channel_torque_off_monitor.sv
// self-checking bench for the torque-off monitor
`timescale 1ns/1ps
`default_nettype none
module tb_dual_channel_torque_off_monitor;
    localparam int E40_LIM = 60;
    localparam int FLT_LIM = 120;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic want_a = 1'b1;
    logic want_b = 1'b1;
    logic start_cmd = 1'b0;
    logic stop_cmd = 1'b0;
    logic fault_reset = 1'b0;
    logic auto_rst = 1'b0;
    wire logic ch_a;
    wire logic ch_b;
    wire logic torque_enable;
    wire logic safe_torque_cutoff;
    wire logic running;
    wire logic [7:0] fault_code;
    wire logic [10:0] obs = {fault_code, running, torque_enable, safe_torque_cutoff};
    int fail_count = 0;
    int num_checks = 0;
    // 100 MHz clock
    always #5 mclk = ~mclk;
    // far side contacts and the monitor with short counts
    dctom_contacts far_u (.mclk(mclk), .want_a(want_a), .want_b(want_b), .ch_a(ch_a), .ch_b(ch_b));
    dctom_monitor #(.FILT_CYC(4), .IND_E40_CYC(40), .IND_FLT_CYC(100), .AB_DLY_CYC(20)) dut_u (
        .mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .safe_channel_a(ch_a), .safe_channel_b(ch_b),
        .start_cmd(start_cmd), .stop_cmd(stop_cmd), .fault_reset(fault_reset), .fault_autoreset_setting(auto_rst),
        .torque_enable(torque_enable), .safe_torque_cutoff(safe_torque_cutoff), .running(running),
        .fault_code(fault_code), .fault_active());
    ////////////////////////////////////////
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(1);
    endtask
    // bounded wait, so a missing code cannot hang the run
    task automatic wait_code(input logic [7:0] code, input int lim);
        for (int n = 0; n < lim && fault_code !== code; n++)
            cyc(1);
    endtask
    task automatic set_ch(input logic a, input logic b);
        want_a = a;
        want_b = b;
    endtask
    task automatic power_cycle();
        rst_n = 1'b0;
        set_ch(1'b1, 1'b1);
        cyc(10);
        rst_n = 1'b1;
        cyc(12);
    endtask
    // both open while running, refused restart, manual clear
    task automatic t_both_open();
        pulse(start_cmd);
        check(obs, {8'h00, 3'b110});
        pulse(stop_cmd);
        check(obs, {8'h00, 3'b000});
        pulse(start_cmd);
        check(obs, {8'h00, 3'b110});
        set_ch(1'b0, 1'b0);
        wait_code(8'h28, E40_LIM);
        check(obs, {8'h28, 3'b001});
        pulse(fault_reset);
        pulse(start_cmd);
        check(obs, {8'h28, 3'b001});
        set_ch(1'b1, 1'b1);
        cyc(12);
        check(obs, {8'h28, 3'b001});
        pulse(fault_reset);
        pulse(start_cmd);
        check(obs, {8'h00, 3'b110});
    endtask
    // automatic clear, motor still waits for start
    task automatic t_auto();
        auto_rst = 1'b1;
        set_ch(1'b0, 1'b0);
        wait_code(8'h28, E40_LIM);
        set_ch(1'b1, 1'b1);
        cyc(14);
        check(obs, {8'h00, 3'b000});
        auto_rst = 1'b0;
    endtask
    // one channel opens, latch survives, then the other side opens alone
    task automatic t_single(input logic open_a, input logic [7:0] code);
        pulse(start_cmd);
        set_ch(!open_a, open_a);
        wait_code(code, FLT_LIM);
        check(obs, {code, 3'b001});
        set_ch(1'b1, 1'b1);
        cyc(30);
        pulse(fault_reset);
        pulse(start_cmd);
        check(obs, {code, 3'b001});
        set_ch(open_a, !open_a);
        wait_code(8'h2B, FLT_LIM);
        check(obs, {8'h2B, 3'b001});
        power_cycle();
        check(obs, {8'h00, 3'b000});
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        power_cycle();
        t_both_open();
        t_auto();
        t_single(1'b1, 8'h29);
        t_single(1'b0, 8'h2A);
        report_and_stop();
    end
    // watchdog, tests need about 400 cycles
    initial
    begin
        #100000;
        fail_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
